// file: core/ddrmi_mode_decode.sv
// Purpose: Decodes mode and extended mode writes and tracks bring-up on the command pins.
// Assumes: The memory clock pin is slow enough for the system clock to find its edges.
// Notes: Register contents are readable over the plain register port.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ddrmi_mode_decode
    import ddrmi_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_mem_clk,
    input wire logic i_clock_enable,
    input wire logic i_chip_select_n,
    input wire logic i_row_strobe_n,
    input wire logic i_col_strobe_n,
    input wire logic i_write_enable_n,
    input wire logic i_bank_select_bit0,
    input wire logic i_bank_select_bit1,
    input wire logic [ADDR_PINS-1:0] i_addr,
    input wire logic i_termination_control,
    input wire logic [BUS_AW-1:0] i_reg_addr,
    input wire logic [BUS_DW-1:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [BUS_DW-1:0] o_reg_rdata,
    output logic o_burst_len_eight,
    output logic o_burst_len_invalid,
    output logic o_burst_interleave,
    output logic [2:0] o_read_latency,
    output logic o_test_mode,
    output logic [2:0] o_write_recovery,
    output logic o_dll_reset,
    output logic o_dll_enable,
    output logic o_dll_locked,
    output logic o_drive_reduced,
    output logic [2:0] o_additive_latency,
    output logic [1:0] o_termination_setting,
    output logic o_termination_active,
    output logic o_strobe_single_ended,
    output logic o_rdqs_enable,
    output logic [2:0] o_calib_mode,
    output logic o_init_ready,
    output logic o_order_error
);

    localparam int SYNC_W = ADDR_PINS + 9;

    typedef struct packed {
        logic clk_prev;
        logic cke;
        logic term_act;
        logic [ADDR_PINS-1:0] mr;
        logic [ADDR_PINS-1:0] emr1;
        logic [ADDR_PINS-1:0] emr2;
        logic [ADDR_PINS-1:0] emr3;
        logic [DLL_CNT_W-1:0] dll_cnt;
        logic dll_locked;
        logic dll_reset;
        logic bl8;
        logic bl_invalid;
        logic interleave;
        logic [2:0] rl;
        logic test;
        logic [2:0] wr_rec;
        logic dll_en;
        logic drv_red;
        logic [2:0] al;
        logic [1:0] term_set;
        logic strobe_se;
        logic rdqs_en;
        logic [2:0] calib;
        ddrmi_stage_t stage;
        logic ready;
        logic [1:0] refreshes;
        logic order_err;
        logic dec_en;
        logic [BUS_DW-1:0] rdata;
    } ddrmi_state_t;

    ddrmi_state_t st_r;
    ddrmi_state_t st_nxt;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins;
    logic link_rise;
    logic [2:0] cmd;
    logic [1:0] bank;
    logic [ADDR_PINS-1:0] a;
    logic cmd_valid;
    logic mode_wr;
    logic pre_all;
    logic refresh;
    logic idle;
    logic [BUS_DW-1:0] status;

    assign pins_raw = {i_mem_clk, i_clock_enable, i_chip_select_n, i_row_strobe_n,
        i_col_strobe_n, i_write_enable_n, i_bank_select_bit1, i_bank_select_bit0,
        i_termination_control, i_addr};

    ddrmi_pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_pins(pins_raw),
        .o_pins(pins)
    );

    // Command decode on each rising memory clock edge seen after sync.
    assign link_rise = pins[SYNC_W-1] && !st_r.clk_prev;
    assign cmd = pins[SYNC_W-4:SYNC_W-6];
    assign bank = pins[SYNC_W-7:SYNC_W-8];
    assign a = pins[ADDR_PINS-1:0];
    assign cmd_valid = link_rise && st_r.dec_en && pins[SYNC_W-2] && !pins[SYNC_W-3];
    assign mode_wr = cmd_valid && (cmd == CMD_MODE_WRITE);
    assign pre_all = cmd_valid && (cmd == CMD_PRECHARGE) && a[PRE_ALL_BIT];
    assign refresh = cmd_valid && (cmd == CMD_REFRESH);
    assign idle = !cmd_valid || (cmd == CMD_NOP);

    // Status word showing bring-up progress and the pin levels taken at the last rising memory clock edge.
    always_comb
    begin
        status = '0;
        status[STS_STAGE_LSB +: 4] = st_r.stage;
        status[STS_READY] = (st_r.stage == STG_READY);
        status[STS_ORDER_ERR] = st_r.order_err;
        status[STS_DLL_LOCKED] = st_r.dll_locked;
        status[STS_BL_INVALID] = st_r.bl_invalid;
        status[STS_CKE] = st_r.cke;
        status[STS_TERM] = st_r.term_act;
    end

    // Next-state logic for pins, mode registers, tracker and register port.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.dll_reset = 1'b0;
        st_nxt.clk_prev = pins[SYNC_W-1];
        if (link_rise)
        begin
            st_nxt.cke = pins[SYNC_W-2];
            st_nxt.term_act = pins[ADDR_PINS];
        end
        // Only the addressed register is loaded; array state is never touched.
        if (mode_wr)
        begin
            case (bank)
                BANK_MAIN:
                begin
                    st_nxt.mr = a;
                    st_nxt.bl8 = (a[MR_BL_LSB +: 3] == BL_EIGHT);
                    st_nxt.bl_invalid = (a[MR_BL_LSB +: 3] != BL_EIGHT)
                        && (a[MR_BL_LSB +: 3] != BL_FOUR);
                    st_nxt.interleave = a[MR_ORDER];
                    st_nxt.rl = a[MR_RL_LSB +: 3];
                    st_nxt.test = a[MR_TEST];
                    st_nxt.wr_rec = a[MR_WR_LSB +: 3];
                    st_nxt.dll_reset = a[MR_DLL_RESET];
                    if (a[MR_DLL_RESET])
                    begin
                        st_nxt.dll_cnt = '0;
                        st_nxt.dll_locked = 1'b0;
                    end
                end
                BANK_EXT_ONE:
                begin
                    st_nxt.emr1 = a;
                    st_nxt.dll_en = !a[E1_DLL_DIS];
                    st_nxt.drv_red = a[E1_DRV_RED];
                    st_nxt.al = a[E1_AL_LSB +: 3];
                    st_nxt.term_set = {a[E1_TERM_HI], a[E1_TERM_LO]};
                    st_nxt.strobe_se = a[E1_STROBE_SE];
                    st_nxt.rdqs_en = a[E1_RDQS_EN];
                    st_nxt.calib = a[E1_CAL_LSB +: 3];
                    if (a[E1_DLL_DIS])
                    begin
                        st_nxt.dll_locked = 1'b0;
                    end
                end
                BANK_EXT_TWO:
                begin
                    st_nxt.emr2 = a;
                end
                default:
                begin
                    st_nxt.emr3 = a;
                end
            endcase
        end
        // Delay line locks after the fixed count of memory clocks; every rise with the delay line enabled counts,
        // except one whose write resets or disables it; only a reset write clears the count and so restarts it.
        if (link_rise && st_r.dll_en && !st_r.dll_locked
            && !(mode_wr && bank == BANK_MAIN && a[MR_DLL_RESET])
            && !(mode_wr && bank == BANK_EXT_ONE && a[E1_DLL_DIS]))
        begin
            if (st_r.dll_cnt == DLL_CNT_W'(DLL_LOCK_CYCLES - 1))
            begin
                st_nxt.dll_locked = 1'b1;
            end
            else
            begin
                st_nxt.dll_cnt = st_r.dll_cnt + 1'b1;
            end
        end
        // Bring-up tracker: an out-of-order command flags an error, except a locked extended-one write in a calibration stage.
        if (link_rise && st_r.stage != STG_READY && !st_r.order_err)
        begin
            case (st_r.stage)
                STG_POWER:
                begin
                    if (pins[SYNC_W-2])
                    begin
                        st_nxt.stage = STG_PRE_ONE;
                    end
                end
                STG_PRE_ONE:
                begin
                    st_nxt.stage = pre_all ? STG_EXT_TWO : st_r.stage;
                    st_nxt.order_err = !idle && !pre_all;
                end
                STG_EXT_TWO:
                begin
                    st_nxt.stage = idle ? st_r.stage : STG_EXT_THREE;
                    st_nxt.order_err = !idle && !(mode_wr && bank == BANK_EXT_TWO);
                end
                STG_EXT_THREE:
                begin
                    st_nxt.stage = idle ? st_r.stage : STG_EXT_ONE;
                    st_nxt.order_err = !idle && !(mode_wr && bank == BANK_EXT_THREE);
                end
                STG_EXT_ONE:
                begin
                    st_nxt.stage = idle ? st_r.stage : STG_DLL_RESET;
                    st_nxt.order_err = !idle && !(mode_wr && bank == BANK_EXT_ONE
                        && !a[E1_DLL_DIS] && a[E1_CAL_LSB +: 3] == CAL_EXIT);
                end
                STG_DLL_RESET:
                begin
                    st_nxt.stage = idle ? st_r.stage : STG_PRE_TWO;
                    st_nxt.order_err = !idle && !(mode_wr && bank == BANK_MAIN
                        && a[MR_DLL_RESET]);
                end
                STG_PRE_TWO:
                begin
                    st_nxt.stage = pre_all ? STG_REFRESH : st_r.stage;
                    st_nxt.refreshes = '0;
                    st_nxt.order_err = !idle && !pre_all;
                end
                STG_REFRESH:
                begin
                    if (refresh && st_r.refreshes != INIT_REFRESHES)
                    begin
                        st_nxt.refreshes = st_r.refreshes + 1'b1;
                    end
                    if (mode_wr && bank == BANK_MAIN && !a[MR_DLL_RESET]
                        && st_r.refreshes == INIT_REFRESHES)
                    begin
                        st_nxt.stage = STG_CAL_DEFAULT;
                    end
                    else
                    begin
                        st_nxt.order_err = !idle && !refresh;
                    end
                end
                STG_CAL_DEFAULT, STG_CAL_EXIT:
                begin
                    // Calibration writes before lock are too early.
                    if (mode_wr && bank == BANK_EXT_ONE && st_r.dll_locked)
                    begin
                        if (a[E1_CAL_LSB +: 3] == CAL_DEFAULT)
                        begin
                            st_nxt.stage = STG_CAL_EXIT;
                        end
                        else if (a[E1_CAL_LSB +: 3] == CAL_EXIT
                            && st_r.stage == STG_CAL_EXIT)
                        begin
                            st_nxt.stage = STG_READY;
                        end
                    end
                    else
                    begin
                        st_nxt.order_err = !idle;
                    end
                end
                default:
                begin
                    st_nxt.stage = STG_POWER;
                end
            endcase
        end
        // Register port: writes steer control, reads answer next cycle.
        st_nxt.rdata = '0;
        if (i_reg_write && i_reg_addr == OFS_CONTROL)
        begin
            st_nxt.dec_en = i_reg_wdata[CTL_DECODE_EN];
            if (i_reg_wdata[CTL_RESTART])
            begin
                st_nxt.stage = STG_POWER;
                st_nxt.order_err = 1'b0;
            end
        end
        if (i_reg_read)
        begin
            case (i_reg_addr)
                OFS_MAIN_MODE: st_nxt.rdata = BUS_DW'(st_r.mr);
                OFS_EXT_ONE: st_nxt.rdata = BUS_DW'(st_r.emr1);
                OFS_EXT_TWO: st_nxt.rdata = BUS_DW'(st_r.emr2);
                OFS_EXT_THREE: st_nxt.rdata = BUS_DW'(st_r.emr3);
                OFS_STATUS: st_nxt.rdata = status;
                OFS_CONTROL: st_nxt.rdata = BUS_DW'(st_r.dec_en);
                default: st_nxt.rdata = '0;
            endcase
        end
        // Ready flag is registered so the output comes straight from a flop.
        st_nxt.ready = (st_nxt.stage == STG_READY);
    end

    // State register; clock enable low freezes all of it.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_r <= '0;
            st_r.dec_en <= CTL_DECODE_EN_RST;
            st_r.stage <= STG_POWER;
        end
        else if (i_clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from state flops.
    assign o_reg_rdata = st_r.rdata;
    assign o_burst_len_eight = st_r.bl8;
    assign o_burst_len_invalid = st_r.bl_invalid;
    assign o_burst_interleave = st_r.interleave;
    assign o_read_latency = st_r.rl;
    assign o_test_mode = st_r.test;
    assign o_write_recovery = st_r.wr_rec;
    assign o_dll_reset = st_r.dll_reset;
    assign o_dll_enable = st_r.dll_en;
    assign o_dll_locked = st_r.dll_locked;
    assign o_drive_reduced = st_r.drv_red;
    assign o_additive_latency = st_r.al;
    assign o_termination_setting = st_r.term_set;
    assign o_termination_active = st_r.term_act;
    assign o_strobe_single_ended = st_r.strobe_se;
    assign o_rdqs_enable = st_r.rdqs_en;
    assign o_calib_mode = st_r.calib;
    assign o_init_ready = st_r.ready;
    assign o_order_error = st_r.order_err;

    // Checks on the decode.
    property p_main_load;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && mode_wr && bank == BANK_MAIN) |=> (st_r.mr == $past(a));
    endproperty
    a_main_load: assert property (p_main_load)
        else $error("Main register did not take the address pins.");

    property p_reset_one_shot;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && o_dll_reset) |=> !o_dll_reset;
    endproperty
    a_reset_one_shot: assert property (p_reset_one_shot)
        else $error("Delay-line reset held longer than one cycle.");

    property p_burst_len;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && mode_wr && bank == BANK_MAIN && a[2:0] == BL_FOUR)
            |=> !o_burst_len_eight && !o_burst_len_invalid;
    endproperty
    a_burst_len: assert property (p_burst_len)
        else $error("Four-beat burst not decoded.");

    property p_latency;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && mode_wr && bank == BANK_MAIN)
            |=> o_read_latency == $past(a[6:4]) && o_write_recovery == $past(a[11:9]);
    endproperty
    a_latency: assert property (p_latency)
        else $error("Latency or recovery field misplaced.");

    property p_ext_keeps_main;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && mode_wr && bank != BANK_MAIN) |=> $stable(st_r.mr);
    endproperty
    a_ext_keeps_main: assert property (p_ext_keeps_main)
        else $error("Extended write disturbed the main register.");

    property p_main_keeps_ext;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (i_clk_en && mode_wr && bank == BANK_MAIN) |=> $stable(st_r.emr1) && $stable(st_r.emr2);
    endproperty
    a_main_keeps_ext: assert property (p_main_keeps_ext)
        else $error("Main write disturbed other stored state.");

endmodule // ddrmi_mode_decode

// file: core/ddrmi_pin_sync.sv
// Purpose: Three-stage synchroniser for a group of pins from outside the clock domain.
// Assumes: Each bit is an independent level input.
// Notes: A bit updates only when the second and third stages agree.
`timescale 1ns/1ps
module ddrmi_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [WIDTH-1:0] i_pins,
    output logic [WIDTH-1:0] o_pins
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } ddrmi_sync_t;

    ddrmi_sync_t st_r;
    ddrmi_sync_t st_nxt;
    logic [WIDTH-1:0] q_nxt;

    // Each output bit follows only once the later two stages agree.
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        assign q_nxt[b] = (st_r.s2[b] == st_r.s3[b]) ? st_r.s3[b] : st_r.q[b];
    end

    // Shift the pins through the stages.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = i_pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q = q_nxt;
    end

    // Register the state; a low clock enable freezes everything.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_r <= '0;
        end
        else if (i_clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    assign o_pins = st_r.q;

endmodule // ddrmi_pin_sync

// file: core/ddrmi_pkg.sv
// Purpose: Shared constants for the memory mode-program decoder.
// Assumes: Commands are sampled on rising edges of the memory clock pin.
// Notes: Register offsets are byte addresses on the plain register port.
package ddrmi_pkg;

    // Widths of the memory command pins and of the register port.
    localparam int ADDR_PINS = 13;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;

    // Register port offsets.
    localparam logic [7:0] OFS_MAIN_MODE = 8'h00;
    localparam logic [7:0] OFS_EXT_ONE = 8'h04;
    localparam logic [7:0] OFS_EXT_TWO = 8'h08;
    localparam logic [7:0] OFS_EXT_THREE = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CONTROL = 8'h14;

    // Control register bits and reset value.
    localparam int CTL_DECODE_EN = 0;
    localparam int CTL_RESTART = 1;
    localparam logic CTL_DECODE_EN_RST = 1'b1;

    // Status register bit positions.
    localparam int STS_STAGE_LSB = 0;
    localparam int STS_READY = 4;
    localparam int STS_ORDER_ERR = 5;
    localparam int STS_DLL_LOCKED = 6;
    localparam int STS_BL_INVALID = 7;
    localparam int STS_CKE = 8;
    localparam int STS_TERM = 9;

    // Bank select codes that pick the addressed mode register.
    localparam logic [1:0] BANK_MAIN = 2'h0;
    localparam logic [1:0] BANK_EXT_ONE = 2'h1;
    localparam logic [1:0] BANK_EXT_TWO = 2'h2;
    localparam logic [1:0] BANK_EXT_THREE = 2'h3;

    // Command codes on {row strobe, column strobe, write enable}, chip select low.
    localparam logic [2:0] CMD_MODE_WRITE = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // Main mode register fields.
    localparam int MR_BL_LSB = 0;
    localparam int MR_ORDER = 3;
    localparam int MR_RL_LSB = 4;
    localparam int MR_TEST = 7;
    localparam int MR_DLL_RESET = 8;
    localparam int MR_WR_LSB = 9;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;

    // Extended register one fields.
    localparam int E1_DLL_DIS = 0;
    localparam int E1_DRV_RED = 1;
    localparam int E1_TERM_LO = 2;
    localparam int E1_AL_LSB = 3;
    localparam int E1_TERM_HI = 6;
    localparam int E1_CAL_LSB = 7;
    localparam int E1_STROBE_SE = 10;
    localparam int E1_RDQS_EN = 11;
    localparam logic [2:0] CAL_EXIT = 3'h0;
    localparam logic [2:0] CAL_DEFAULT = 3'h7;

    // Precharge-all flag on the address pins.
    localparam int PRE_ALL_BIT = 10;

    // Memory clock cycles between delay-line reset and lock.
    localparam int DLL_LOCK_CYCLES = 200;
    localparam int DLL_CNT_W = 8;

    // Refresh commands needed during bring-up.
    localparam logic [1:0] INIT_REFRESHES = 2'h2;

    // Bring-up stages seen on the command pins.
    typedef enum logic [3:0] {
        STG_POWER,
        STG_PRE_ONE,
        STG_EXT_TWO,
        STG_EXT_THREE,
        STG_EXT_ONE,
        STG_DLL_RESET,
        STG_PRE_TWO,
        STG_REFRESH,
        STG_MAIN,
        STG_CAL_DEFAULT,
        STG_CAL_EXIT,
        STG_READY
    } ddrmi_stage_t;

endpackage

// file: verif/ddrmi_ctrl_model.sv
// Purpose: Controller model that drives the memory command pins.
// Assumes: The memory clock runs free at 160 ns.
// Notes: Pins change on falling memory clock edges, far from the sampling edge.
`timescale 1ns/1ps
module ddrmi_ctrl_model
    import ddrmi_pkg::*;
(
    output logic o_mem_clk,
    output logic o_cke,
    output logic o_cs_n,
    output logic [2:0] o_cmd,
    output logic [1:0] o_bank,
    output logic [ADDR_PINS-1:0] o_addr,
    output logic o_term
);
    // Power-up levels: enable and termination low, device deselected.
    initial
    begin
        o_mem_clk = 1'b0;
        o_cke = 1'b0;
        o_term = 1'b0;
        o_cs_n = 1'b1;
        o_cmd = CMD_NOP;
        o_bank = 2'h0;
        o_addr = '0;
    end
    // Free-running memory clock.
    always #80 o_mem_clk = ~o_mem_clk;
    // Raises enable under idle commands, then idles longer than 400 ns.
    task automatic raise_cke();
        @(negedge o_mem_clk);
        o_cke = 1'b1;
        repeat (3) @(negedge o_mem_clk);
    endtask
    // Changes the termination pin level away from the sampling edge.
    task automatic set_term(input logic lvl);
        @(negedge o_mem_clk);
        o_term = lvl;
    endtask
    // One command for one clock; released lines then show inverted values.
    task automatic send(input logic [2:0] cmd, input logic [1:0] bank, input logic [12:0] a);
        @(negedge o_mem_clk);
        o_cs_n = 1'b0;
        o_cmd = cmd;
        o_bank = bank;
        o_addr = a;
        @(negedge o_mem_clk);
        o_cs_n = 1'b1;
        o_cmd = ~cmd;
        o_bank = ~bank;
        o_addr = ~a;
        repeat (2) @(negedge o_mem_clk);
    endtask
endmodule // ddrmi_ctrl_model

// file: verif/ddrmi_mode_decode_test.sv
// Purpose: Self-checking bench for the mode-program decoder.
// Assumes: Controller model drives pins; bench drives the register port.
// Notes: Each scenario is a task that judges its own outcome.
`timescale 1ns/1ps
module ddrmi_mode_decode_test
    import ddrmi_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mclk, cke, cs_n, term, wr = 1'b0, rd = 1'b0;
    logic [2:0] cmd, rl, wrc, al, cal;
    logic [1:0] bank;
    logic [12:0] addr;
    logic [7:0] ra = 8'h00;
    logic [31:0] wd = 32'h0, rdata, v;
    logic bl8, bli, bil, tm, dlr, dle, lck, drd, sse, rdy, oerr, tact, rdq;
    logic [1:0] tset;
    int error_cnt = 0, tests_run = 0, pulses = 0;
    always #5 clk = ~clk;
    // Counts delay-line reset pulses.
    always @(posedge clk) if (dlr === 1'b1) pulses <= pulses + 1;
    ddrmi_ctrl_model m (.o_mem_clk(mclk), .o_cke(cke), .o_cs_n(cs_n), .o_cmd(cmd),
        .o_bank(bank), .o_addr(addr), .o_term(term));
    ddrmi_mode_decode i_ddrmi_mode_decode (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_clk_en(1'b1), .i_mem_clk(mclk), .i_clock_enable(cke), .i_chip_select_n(cs_n),
        .i_row_strobe_n(cmd[2]), .i_col_strobe_n(cmd[1]), .i_write_enable_n(cmd[0]),
        .i_bank_select_bit0(bank[0]), .i_bank_select_bit1(bank[1]), .i_addr(addr),
        .i_termination_control(term), .i_reg_addr(ra), .i_reg_wdata(wd),
        .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata), .o_burst_len_eight(bl8),
        .o_burst_len_invalid(bli), .o_burst_interleave(bil), .o_read_latency(rl),
        .o_test_mode(tm), .o_write_recovery(wrc), .o_dll_reset(dlr), .o_dll_enable(dle),
        .o_dll_locked(lck), .o_drive_reduced(drd), .o_additive_latency(al),
        .o_termination_setting(tset), .o_termination_active(tact), .o_strobe_single_ended(sse),
        .o_rdqs_enable(rdq), .o_calib_mode(cal), .o_init_ready(rdy), .o_order_error(oerr));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdreg(input logic [7:0] a);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // Reset values of status and control, and an unmapped read.
    task automatic t_reset();
        rdreg(OFS_STATUS);
        check(v, 32'h0);
        rdreg(OFS_CONTROL);
        check(v, 32'h1);
        rdreg(8'h18);
        check(v, 32'h0);
    endtask
    // Full bring-up including the calibration default and exit writes, checking decoded fields along the way.
    task automatic t_bringup();
        #200000;
        m.raise_cke();
        m.send(CMD_PRECHARGE, 2'h0, 13'h0400);
        m.send(CMD_MODE_WRITE, BANK_EXT_TWO, 13'h0000);
        m.send(CMD_MODE_WRITE, BANK_EXT_THREE, 13'h0000);
        m.send(CMD_MODE_WRITE, BANK_EXT_ONE, 13'h0412);
        check({dle, drd, al, sse, cal}, {1'b1, 1'b1, 3'h2, 1'b1, 3'h0});
        m.send(CMD_MODE_WRITE, BANK_MAIN, 13'h074B);
        check({bl8, bil, rl, wrc, lck}, {1'b1, 1'b1, 3'h4, 3'h3, 1'b0});
        m.send(CMD_PRECHARGE, 2'h0, 13'h0400);
        m.send(CMD_REFRESH, 2'h0, 13'h0000);
        m.send(CMD_REFRESH, 2'h0, 13'h0000);
        m.send(CMD_MODE_WRITE, BANK_MAIN, 13'h0452);
        check({bl8, bli, bil, rl, tm, wrc}, {3'h0, 3'h5, 1'b0, 3'h2});
        repeat (200) @(posedge mclk);
        check(lck, 32'h1);
        m.send(CMD_MODE_WRITE, BANK_EXT_ONE, 13'h0792);
        check({cal, al}, {CAL_DEFAULT, 3'h2});
        m.send(CMD_MODE_WRITE, BANK_EXT_ONE, 13'h0412);
        check({cal, rdy, oerr}, {CAL_EXIT, 2'b10});
        rdreg(OFS_STATUS);
        check(v, 32'h15B);
    endtask
    // Rewrites in normal use; bit 8 low never pulses the delay-line reset.
    task automatic t_rewrite();
        m.send(CMD_MODE_WRITE, BANK_MAIN, 13'h04D1);
        check({bli, tm}, 2'b11);
        rdreg(OFS_MAIN_MODE);
        check(v, 32'h4D1);
        m.send(CMD_MODE_WRITE, BANK_MAIN, 13'h0452);
        check({bli, tm, rl}, {2'b00, 3'h5});
        m.set_term(1'b1);
        m.send(CMD_MODE_WRITE, BANK_EXT_ONE, 13'h0C56);
        check({tset, tact, rdq, al}, {2'h3, 2'b11, 3'h2});
        check(pulses, 32'h1);
    endtask
    // Decode disabled ignores writes; restart then an early write is out of order.
    task automatic t_refuse();
        wrreg(OFS_CONTROL, 32'h0);
        m.send(CMD_MODE_WRITE, BANK_MAIN, 13'h0462);
        check(rl, 32'h5);
        wrreg(OFS_CONTROL, 32'h3);
        m.send(CMD_MODE_WRITE, BANK_MAIN, 13'h0452);
        check(oerr, 32'h1);
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_bringup();
        t_rewrite();
        t_refuse();
        print_verdict();
    end
    // Watchdog well past the expected run of about 243 us.
    initial
    begin
        #600000;
        error_cnt++;
        print_verdict();
    end
endmodule // ddrmi_mode_decode_test
